// >>> core/pts_target.sv
`timescale 1ns/100ps
module pts_target (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        frame_l_i,
   input  wire logic        irdy_l_i,
   input  wire logic        idsel_i,
   input  wire logic [31:0] ad_i,
   input  wire logic [3:0]  c_be_l_i,
   output logic [31:0]      ad_o,
   output logic             ad_oe_o,
   output logic             par_o,
   output logic             par_oe_o,
   output logic             devsel_l_o,
   output logic             trdy_l_o,
   output logic             stop_l_o,
   output logic             ctl_oe_o,
   output logic             mrm_en_o
);
   pts_pkg::pts_state_t state, next_state;
   logic [31:0] addr_q,   next_addr_q;
   logic [3:0]  cmd_q,    next_cmd_q;
   logic        cfg_q,    next_cfg_q;
   logic        frame_d,  next_frame_d;
   logic [31:0] next_ad;
   logic        next_ad_oe, next_par, next_par_oe;
   logic        next_devsel_l, next_trdy_l, next_stop_l, next_ctl_oe;
   logic        start, is_io, is_mem, is_cfg, is_wr, hit_now;
   logic        wr_en;
   logic [5:0]  idx;
   logic [31:0] rdata, io_base, mem_base;
   logic        io_en, mem_en, mrm_en;
   logic        done;

   ////////////////////////////////////////////////////////////////////////
   // command decode and claim
   assign start = !frame_l_i && frame_d;
   always_comb begin
      is_io  = 1'b0;
      is_mem = 1'b0;
      is_cfg = 1'b0;
      unique case (c_be_l_i)
         pts_pkg::CMD_IO_RD, pts_pkg::CMD_IO_WR: is_io = 1'b1;
         pts_pkg::CMD_MEM_RD, pts_pkg::CMD_MEM_WR,
         pts_pkg::CMD_MEM_RL: is_mem = 1'b1;
         pts_pkg::CMD_MEM_RM: is_mem = 1'b1;
         pts_pkg::CMD_MEM_WI: is_mem = 1'b1;
         pts_pkg::CMD_CFG_RD, pts_pkg::CMD_CFG_WR: is_cfg = 1'b1;
         default: ;  // ack, special, dual and reserved left unclaimed
      endcase
   end

   // an unprogrammed window is never matched while decode is disabled
   assign hit_now = (is_io && io_en
                     && ad_i[31:pts_pkg::WIN_LSB] == io_base[31:pts_pkg::WIN_LSB])
                 || (is_mem && mem_en
                     && ad_i[31:pts_pkg::WIN_LSB] == mem_base[31:pts_pkg::WIN_LSB])
                 || (is_cfg && idsel_i && ad_i[1:0] == pts_pkg::CFG_TYPE0);

   assign is_wr = cmd_q[0];
   assign done  = !irdy_l_i;
   assign idx   = cfg_q ? addr_q[pts_pkg::CFG_IDX_LSB +: pts_pkg::CFG_IDX_W]
                        : {2'h0, addr_q[pts_pkg::REG_IDX_LSB +: pts_pkg::REG_IDX_W]};
   // lanes are ignored: a write stores the whole longword or nothing
   assign wr_en = (state == pts_pkg::PTS_WR) && done
                  && (c_be_l_i != pts_pkg::BE_NONE);

   pts_reg_store u_store (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .cfg_sel_i  (cfg_q),
      .idx_i      (idx),
      .wr_en_i    (wr_en),
      .wdata_i    (ad_i),
      .rdata_o    (rdata),
      .io_base_o  (io_base),
      .mem_base_o (mem_base),
      .io_en_o    (io_en),
      .mem_en_o   (mem_en),
      .mrm_en_o   (mrm_en)
   );

   ////////////////////////////////////////////////////////////////////////
   // target sequencer
   always_comb begin
      next_state    = state;
      next_addr_q   = addr_q;
      next_cmd_q    = cmd_q;
      next_cfg_q    = cfg_q;
      next_frame_d  = frame_l_i;
      next_ad       = ad_o;
      next_ad_oe    = 1'b0;
      next_devsel_l = devsel_l_o;
      next_trdy_l   = trdy_l_o;
      next_stop_l   = stop_l_o;
      next_ctl_oe   = ctl_oe_o;
      next_par      = ^{ad_o, c_be_l_i};
      next_par_oe   = ad_oe_o;
      unique case (state)
         pts_pkg::PTS_IDLE: begin
            next_ctl_oe   = 1'b0;
            next_devsel_l = 1'b1;
            next_trdy_l   = 1'b1;
            next_stop_l   = 1'b1;
            if (start && hit_now) begin
               next_addr_q = ad_i;
               next_cmd_q  = c_be_l_i;
               next_cfg_q  = is_cfg;
               next_state  = pts_pkg::PTS_ADDR;
            end
         end
         pts_pkg::PTS_ADDR: begin
            next_ctl_oe   = 1'b1;
            next_devsel_l = 1'b0;
            if (is_wr) begin
               next_trdy_l = 1'b0;
               next_state  = pts_pkg::PTS_WR;
            end else begin
               next_state  = pts_pkg::PTS_RD_DEV;
            end
         end
         pts_pkg::PTS_RD_DEV: begin
            // lanes are valid once irdy is up; none enabled reads as zero
            next_ad     = (c_be_l_i == pts_pkg::BE_NONE) ? pts_pkg::DATA_ZERO
                                                         : rdata;
            next_ad_oe  = 1'b1;
            next_trdy_l = 1'b0;
            next_state  = pts_pkg::PTS_RD_DAT;
         end
         pts_pkg::PTS_RD_DAT, pts_pkg::PTS_WR: begin
            next_ad_oe = (state == pts_pkg::PTS_RD_DAT);
            if (done) begin
               next_ad_oe  = 1'b0;
               next_trdy_l = 1'b1;
               if (!frame_l_i) begin
                  next_stop_l = 1'b0;
                  next_state  = pts_pkg::PTS_RETRY;
               end else begin
                  next_devsel_l = 1'b1;
                  next_state    = pts_pkg::PTS_TURN;
               end
            end
         end
         pts_pkg::PTS_RETRY: begin
            // stop holds until the host drops frame
            if (frame_l_i) begin
               next_stop_l   = 1'b1;
               next_devsel_l = 1'b1;
               next_state    = pts_pkg::PTS_TURN;
            end
         end
         pts_pkg::PTS_TURN: begin
            // drive the strobes high one cycle before letting them float
            next_ctl_oe = 1'b0;
            next_state  = pts_pkg::PTS_IDLE;
         end
         default: next_state = pts_pkg::PTS_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state      <= pts_pkg::PTS_IDLE;
         addr_q     <= pts_pkg::DATA_ZERO;
         cmd_q      <= 4'h0;
         cfg_q      <= 1'b0;
         frame_d    <= 1'b1;
         ad_o       <= pts_pkg::DATA_ZERO;
         ad_oe_o    <= 1'b0;
         par_o      <= 1'b0;
         par_oe_o   <= 1'b0;
         devsel_l_o <= 1'b1;
         trdy_l_o   <= 1'b1;
         stop_l_o   <= 1'b1;
         ctl_oe_o   <= 1'b0;
         mrm_en_o   <= 1'b0;
      end else begin
         state      <= next_state;
         addr_q     <= next_addr_q;
         cmd_q      <= next_cmd_q;
         cfg_q      <= next_cfg_q;
         frame_d    <= next_frame_d;
         ad_o       <= next_ad;
         ad_oe_o    <= next_ad_oe;
         par_o      <= next_par;
         par_oe_o   <= next_par_oe;
         devsel_l_o <= next_devsel_l;
         trdy_l_o   <= next_trdy_l;
         stop_l_o   <= next_stop_l;
         ctl_oe_o   <= next_ctl_oe;
         mrm_en_o   <= mrm_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sequence claim_s;
      start && hit_now && state == pts_pkg::PTS_IDLE;
   endsequence

   sequence rd_data_s;
      !devsel_l_o && !ad_oe_o ##1 ad_oe_o && !trdy_l_o;
   endsequence

   sequence wr_phase_s;
      !devsel_l_o && !trdy_l_o && !ad_oe_o;
   endsequence

   bad_cmd_a: assert property (
      (start && state == pts_pkg::PTS_IDLE && !is_io && !is_mem && !is_cfg)
      |-> ##2 devsel_l_o)
      else $error("unsupported command was claimed");

   claim_a: assert property (
      claim_s |-> ##2 !devsel_l_o && ctl_oe_o)
      else $error("decoded hit not claimed");

   no_hit_a: assert property (
      (start && !hit_now && state == pts_pkg::PTS_IDLE) |-> ##2 devsel_l_o)
      else $error("miss was claimed");

   rd_order_a: assert property (
      (claim_s ##1 !is_wr) |-> ##1 rd_data_s)
      else $error("read data not one cycle after devsel");

   rd_zero_a: assert property (
      (state == pts_pkg::PTS_RD_DEV && c_be_l_i == pts_pkg::BE_NONE)
      |=> ad_o == pts_pkg::DATA_ZERO)
      else $error("read with no lanes not zero");

   par_a: assert property (
      ad_oe_o |=> par_oe_o && par_o == ^{$past(ad_o), $past(c_be_l_i)})
      else $error("parity mismatch");

   wr_trdy_a: assert property (
      (state == pts_pkg::PTS_ADDR && is_wr) |=> !trdy_l_o && !devsel_l_o)
      else $error("write not acknowledged");

   wr_skip_a: assert property (
      (state == pts_pkg::PTS_WR && done) |=> ctl_oe_o && trdy_l_o)
      else $error("write phase did not finish");

   retry_a: assert property (
      (!trdy_l_o && done && !frame_l_i) |=> !stop_l_o && trdy_l_o && !devsel_l_o)
      else $error("burst not retried");

   stop_hold_a: assert property (
      (!stop_l_o && !frame_l_i) |=> !stop_l_o)
      else $error("stop dropped before frame");

   end_a: assert property (
      (!trdy_l_o && done && frame_l_i) |=> trdy_l_o && devsel_l_o ##1 !ctl_oe_o)
      else $error("cycle not released");

   wr_land_a: assert property (
      (state == pts_pkg::PTS_WR && done && !cfg_q && c_be_l_i != pts_pkg::BE_NONE)
      |=> rdata == $past(ad_i))
      else $error("write data not stored");

   nolane_wr_a: assert property (
      (state == pts_pkg::PTS_WR && done && c_be_l_i == pts_pkg::BE_NONE)
      |=> $stable(rdata))
      else $error("write with no lanes changed a register");

   wr_phase_a: assert property (
      (claim_s ##1 is_wr)
      |-> ##1 wr_phase_s)
      else $error("write not accepted with devsel and trdy");

   addr_cap_a: assert property (
      claim_s
      |=> addr_q == $past(ad_i) && cmd_q == $past(c_be_l_i) && cfg_q == $past(is_cfg))
      else $error("address or command not captured");

   cfg_idsel_a: assert property (
      (start && state == pts_pkg::PTS_IDLE && is_cfg && !idsel_i)
      |-> ##2 devsel_l_o)
      else $error("configuration access claimed without idsel");

   refuse_quiet_a: assert property (
      (start && !hit_now && state == pts_pkg::PTS_IDLE)
      |-> ##1 !ctl_oe_o ##1 !ctl_oe_o)
      else $error("refused cycle enabled the strobes");

   strobe_quiet_a: assert property (
      !ctl_oe_o
      |-> devsel_l_o && trdy_l_o && stop_l_o)
      else $error("strobe active while not driven");

   ad_owner_a: assert property (
      ad_oe_o
      |-> !devsel_l_o && ctl_oe_o)
      else $error("data driven without devsel");

   stop_shape_a: assert property (
      !stop_l_o
      |-> !devsel_l_o && trdy_l_o && !ad_oe_o)
      else $error("retry without devsel or with trdy");

   turn_float_a: assert property (
      $rose(devsel_l_o)
      |=> devsel_l_o && !ctl_oe_o)
      else $error("strobes not floated after release");
endmodule : pts_target

// >>> core/pts_pkg.sv
package pts_pkg;
   localparam logic [3:0] CMD_IO_RD   = 4'h2;
   localparam logic [3:0] CMD_IO_WR   = 4'h3;
   localparam logic [3:0] CMD_MEM_RD  = 4'h6;
   localparam logic [3:0] CMD_MEM_WR  = 4'h7;
   localparam logic [3:0] CMD_CFG_RD  = 4'hA;
   localparam logic [3:0] CMD_CFG_WR  = 4'hB;
   localparam logic [3:0] CMD_MEM_RM  = 4'hC;
   localparam logic [3:0] CMD_MEM_RL  = 4'hE;
   localparam logic [3:0] CMD_MEM_WI  = 4'hF;
   localparam logic [3:0] BE_NONE     = 4'hF;
   localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
   // register window: 16 longwords on an 8-byte stride, 128 bytes
   localparam int         WIN_LSB     = 7;
   localparam int         REG_IDX_LSB = 3;
   localparam int         REG_IDX_W   = 4;
   localparam int         REG_CNT     = 16;
   // configuration space: 64 longwords, 256 bytes
   localparam int         CFG_IDX_LSB = 2;
   localparam int         CFG_IDX_W   = 6;
   localparam logic [5:0] CFG_ID      = 6'h00;
   localparam logic [5:0] CFG_CMD     = 6'h01;
   localparam logic [5:0] CFG_IO_BAR  = 6'h04;
   localparam logic [5:0] CFG_MEM_BAR = 6'h05;
   localparam int         CMD_IO_EN   = 0;
   localparam int         CMD_MEM_EN  = 1;
   localparam logic [1:0] CMD_EN_RST  = 2'h0;
   localparam logic [1:0] CFG_TYPE0   = 2'h0;
   localparam logic [31:0] IO_BAR_FLAG = 32'h0000_0001;
   localparam logic [3:0] BUS_MODE_IDX = 4'h0;
   localparam int         MRM_EN_BIT   = 21;
   localparam logic [31:0] REG_RST     = 32'h0000_0000;
   typedef enum logic [2:0] {
      PTS_IDLE, PTS_ADDR, PTS_RD_DEV, PTS_RD_DAT, PTS_WR, PTS_RETRY, PTS_TURN
   } pts_state_t;
endpackage : pts_pkg

// >>> core/pts_reg_store.sv
`timescale 1ns/100ps
module pts_reg_store #(
   parameter logic [31:0] DEVICE_ID = 32'h0001_0001  // arbitrary value
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        cfg_sel_i,
   input  wire logic [5:0]  idx_i,
   input  wire logic        wr_en_i,
   input  wire logic [31:0] wdata_i,
   output logic [31:0]      rdata_o,
   output logic [31:0]      io_base_o,
   output logic [31:0]      mem_base_o,
   output logic             io_en_o,
   output logic             mem_en_o,
   output logic             mrm_en_o
);
   logic [31:0] ctl_reg      [pts_pkg::REG_CNT];
   logic [31:0] next_ctl_reg [pts_pkg::REG_CNT];
   logic [1:0]  cmd_en,   next_cmd_en;
   logic [31:0] io_bar,   next_io_bar;
   logic [31:0] mem_bar,  next_mem_bar;
   logic [3:0]  cidx;
   // window low bits read zero, except the io flag in bit 0, so sizing by software sees 128 bytes
   localparam logic [31:0] BAR_MASK = ~((32'h1 << pts_pkg::WIN_LSB) - 32'h1);

   assign cidx = idx_i[pts_pkg::REG_IDX_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_ctl_reg = ctl_reg;
      next_cmd_en  = cmd_en;
      next_io_bar  = io_bar;
      next_mem_bar = mem_bar;
      if (wr_en_i && !cfg_sel_i) begin
         next_ctl_reg[cidx] = wdata_i;
      end
      if (wr_en_i && cfg_sel_i) begin
         unique case (idx_i)
            pts_pkg::CFG_CMD: begin
               next_cmd_en = {wdata_i[pts_pkg::CMD_MEM_EN], wdata_i[pts_pkg::CMD_IO_EN]};
            end
            pts_pkg::CFG_IO_BAR:  next_io_bar  = wdata_i & BAR_MASK;
            pts_pkg::CFG_MEM_BAR: next_mem_bar = wdata_i & BAR_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < pts_pkg::REG_CNT; i++) begin
            ctl_reg[i] <= pts_pkg::REG_RST;
         end
         cmd_en  <= pts_pkg::CMD_EN_RST;
         io_bar  <= pts_pkg::REG_RST;
         mem_bar <= pts_pkg::REG_RST;
      end else begin
         ctl_reg <= next_ctl_reg;
         cmd_en  <= next_cmd_en;
         io_bar  <= next_io_bar;
         mem_bar <= next_mem_bar;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // unimplemented configuration words read as zero
   always_comb begin
      rdata_o = pts_pkg::DATA_ZERO;
      if (!cfg_sel_i) begin
         rdata_o = ctl_reg[cidx];
      end else begin
         unique case (idx_i)
            pts_pkg::CFG_ID:      rdata_o = DEVICE_ID;
            pts_pkg::CFG_CMD:     rdata_o = {30'h0, cmd_en};
            pts_pkg::CFG_IO_BAR:  rdata_o = io_bar | pts_pkg::IO_BAR_FLAG;
            pts_pkg::CFG_MEM_BAR: rdata_o = mem_bar;
            default:              rdata_o = pts_pkg::DATA_ZERO;
         endcase
      end
   end

   assign io_base_o  = io_bar;
   assign mem_base_o = mem_bar;
   assign io_en_o    = cmd_en[pts_pkg::CMD_IO_EN];
   assign mem_en_o   = cmd_en[pts_pkg::CMD_MEM_EN];
   assign mrm_en_o   = ctl_reg[pts_pkg::BUS_MODE_IDX][pts_pkg::MRM_EN_BIT];
endmodule : pts_reg_store

// >>> testbench/pts_host.sv
`timescale 1ns/100ps
module pts_host (
   input  wire logic        clk_i,
   input  wire logic        devsel_l_i,
   input  wire logic        trdy_l_i,
   input  wire logic        stop_l_i,
   input  wire logic        ctl_oe_i,
   input  wire logic        par_i,
   input  wire logic        par_oe_i,
   input  wire logic [31:0] ad_i,
   output logic             frame_l_o,
   output logic             irdy_l_o,
   output logic             idsel_o,
   output logic [31:0]      ad_o,
   output logic [3:0]       c_be_l_o
);
   initial begin
      frame_l_o <= 1'b1;
      irdy_l_o <= 1'b1;
      idsel_o <= 1'b0;
      ad_o <= 32'h0;
      c_be_l_o <= 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one single-phase access; n and dv count edges after the address edge, -1 if never
   task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
                       input logic [31:0] wd, input logic sel, input logic burst,
                       output logic [31:0] rd, output int n, output int dv,
                       output logic [1:0] pv, output logic st);
      int k;
      rd = 32'h0;
      n = -1;
      dv = -1;
      st = 1'b0;
      @(posedge clk_i);
      frame_l_o <= 1'b0;
      ad_o <= addr;
      c_be_l_o <= cmd;
      idsel_o <= sel;
      @(posedge clk_i);
      frame_l_o <= ~burst;
      irdy_l_o <= 1'b0;
      idsel_o <= 1'b0;
      c_be_l_o <= be;
      // on reads the host drives the inverted address on ad, so the line shows no stale value
      ad_o <= cmd[0] ? wd : ~addr;
      for (k = 1; k <= 6 && n < 0; k++) begin
         @(posedge clk_i);
         if (!devsel_l_i && dv < 0) dv = k;
         if (!trdy_l_i) begin
            n = k;
            rd = ad_i;
         end
      end
      ad_o <= ~ad_o;
      if (burst && n > 0) begin
         for (k = 0; k < 4 && !st; k++) begin
            @(posedge clk_i);
            st = !stop_l_i;
         end
      end
      frame_l_o <= 1'b1;
      irdy_l_o <= 1'b1;
      @(posedge clk_i);
      pv = {par_oe_i, par_i};
      for (k = 0; k < 8 && ctl_oe_i; k++) @(posedge clk_i);
      if (ctl_oe_i) n = 99;
   endtask : xfer
endmodule : pts_host

// >>> testbench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam logic [31:0] IO_B  = 32'h0000_1000;
   localparam logic [31:0] MEM_B = 32'h8000_0000;
   logic        mclk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        frame_l, irdy_l, idsel, d_ad_oe, par, par_oe, devsel_l, trdy_l, stop_l;
   logic        ctl_oe, mrm_en, st;
   logic [31:0] h_ad, d_ad, rd;
   logic [3:0]  c_be_l;
   logic [1:0]  pv;
   int          n, dv;
   int          error_cnt = 0;
   int          n_compared = 0;
   wire logic [31:0] ad_bus = d_ad_oe ? d_ad : h_ad;
   always #5 mclk_i = ~mclk_i;
   pts_target u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .frame_l_i(frame_l),
      .irdy_l_i(irdy_l), .idsel_i(idsel), .ad_i(ad_bus), .c_be_l_i(c_be_l), .ad_o(d_ad),
      .ad_oe_o(d_ad_oe), .par_o(par), .par_oe_o(par_oe), .devsel_l_o(devsel_l),
      .trdy_l_o(trdy_l), .stop_l_o(stop_l), .ctl_oe_o(ctl_oe), .mrm_en_o(mrm_en));
   pts_host u_host (.clk_i(mclk_i), .devsel_l_i(devsel_l), .trdy_l_i(trdy_l),
      .stop_l_i(stop_l), .ctl_oe_i(ctl_oe), .par_i(par), .par_oe_i(par_oe), .ad_i(ad_bus),
      .frame_l_o(frame_l), .irdy_l_o(irdy_l), .idsel_o(idsel), .ad_o(h_ad), .c_be_l_o(c_be_l));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   task automatic acc(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
                      input logic [31:0] wd, input logic sel, input logic burst);
      u_host.xfer(cmd, addr, be, wd, sel, burst, rd, n, dv, pv, st);
      if (n == 99) begin
         error_cnt++;
         summarize();
      end
   endtask : acc
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      `CHK("devsel idle", 1'b1, devsel_l)
      `CHK("drivers off", 3'h0, {d_ad_oe, par_oe, ctl_oe})
      `CHK("mrm reset", 1'b0, mrm_en)
      acc(pts_pkg::CMD_CFG_RD, {24'h0, pts_pkg::CFG_CMD, 2'h0}, 4'h0, 32'h0, 1'b1, 1'b0);
      `CHK("cfg cmd reset", 32'h0, rd)
      acc(pts_pkg::CMD_IO_RD, 32'h0, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("decode off", -1, dv)
   endtask : t_reset
   task automatic t_config;
      acc(pts_pkg::CMD_CFG_WR, {24'h0, pts_pkg::CFG_IO_BAR, 2'h0}, 4'h0, IO_B, 1'b1, 1'b0);
      `CHK("cfg wr done", 2, n)
      acc(pts_pkg::CMD_CFG_WR, {24'h0, pts_pkg::CFG_MEM_BAR, 2'h0}, 4'h0, MEM_B, 1'b1, 1'b0);
      acc(pts_pkg::CMD_CFG_WR, {24'h0, pts_pkg::CFG_CMD, 2'h0}, 4'h0, 32'h3, 1'b1, 1'b0);
      acc(pts_pkg::CMD_CFG_RD, {24'h0, pts_pkg::CFG_IO_BAR, 2'h0}, 4'h0, 32'h0, 1'b1, 1'b0);
      `CHK("io bar", IO_B | pts_pkg::IO_BAR_FLAG, rd)
      `CHK("cfg claim", 2, dv)
      acc(pts_pkg::CMD_CFG_RD, {24'h0, pts_pkg::CFG_IO_BAR, 2'h0}, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("no idsel", -1, dv)
   endtask : t_config
   task automatic t_cmds;
      logic [3:0] wc [2] = '{pts_pkg::CMD_MEM_WR, pts_pkg::CMD_MEM_WI};
      logic [3:0] rc [3] = '{pts_pkg::CMD_MEM_RD, pts_pkg::CMD_MEM_RL, pts_pkg::CMD_MEM_RM};
      logic [31:0] v;
      acc(pts_pkg::CMD_IO_WR, IO_B + 32'h8, 4'hE, 32'hA5A5_0001, 1'b0, 1'b0);
      `CHK("io wr done", 2, n)
      `CHK("io wr sel", 2, dv)
      acc(pts_pkg::CMD_IO_RD, IO_B + 32'h8, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("io rd data", 32'hA5A5_0001, rd)
      `CHK("io rd sel", 2, dv)
      `CHK("io rd done", 3, n)
      `CHK("io rd par", {1'b1, ^{32'hA5A5_0001, 4'h0}}, pv)
      for (int i = 0; i < 2; i++) begin
         for (int j = 0; j < 3; j++) begin
            v = 32'h1234_5600 | 32'(i * 4 + j);
            acc(wc[i], MEM_B + 32'h10, 4'h0, v, 1'b0, 1'b0);
            `CHK("mem wr done", 2, n)
            acc(rc[j], MEM_B + 32'h10, 4'h0, 32'h0, 1'b0, 1'b0);
            `CHK("mem rd data", v, rd)
         end
      end
   endtask : t_cmds
   task automatic t_lanes;
      acc(pts_pkg::CMD_IO_WR, IO_B + 32'h8, 4'hF, 32'h0BAD_0BAD, 1'b0, 1'b0);
      `CHK("nolane wr done", 2, n)
      acc(pts_pkg::CMD_IO_RD, IO_B + 32'h8, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("nolane kept", 32'hA5A5_0001, rd)
      acc(pts_pkg::CMD_IO_RD, IO_B + 32'h8, 4'hF, 32'h0, 1'b0, 1'b0);
      `CHK("nolane rd", pts_pkg::DATA_ZERO, rd)
      `CHK("nolane par", 2'h2, pv)
   endtask : t_lanes
   task automatic t_refuse;
      logic [3:0] bad [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD};
      for (int i = 0; i < 7; i++) begin
         acc(bad[i], IO_B + 32'h8, 4'h0, 32'h0, 1'b0, 1'b0);
         `CHK("bad cmd", -1, dv)
      end
      acc(pts_pkg::CMD_IO_RD, IO_B + 32'h80, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("io miss", -1, dv)
      acc(pts_pkg::CMD_MEM_RD, IO_B, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("mem miss", -1, dv)
   endtask : t_refuse
   task automatic t_burst;
      acc(pts_pkg::CMD_MEM_WR, MEM_B + 32'h18, 4'h0, 32'hCAFE_0003, 1'b0, 1'b1);
      `CHK("burst first", 2, n)
      `CHK("burst stop", 1'b1, st)
      acc(pts_pkg::CMD_MEM_RD, MEM_B + 32'h18, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("burst word", 32'hCAFE_0003, rd)
   endtask : t_burst
   task automatic t_mode;
      acc(pts_pkg::CMD_IO_WR, IO_B, 4'h0, 32'h1 << pts_pkg::MRM_EN_BIT, 1'b0, 1'b0);
      `CHK("mrm on", 1'b1, mrm_en)
      acc(pts_pkg::CMD_IO_WR, IO_B, 4'h0, 32'h0, 1'b0, 1'b0);
      `CHK("mrm off", 1'b0, mrm_en)
   endtask : t_mode
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      t_reset();
      t_config();
      t_cmds();
      t_lanes();
      t_refuse();
      t_burst();
      t_mode();
      summarize();
   end
endmodule : testbench
